/* logic/battery_switchover_control.sv */
// battery switch-over control with apb registers and interrupt
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// overview
// ------------------------------------------------------------
// decides which supply feeds the core and tells the power path.
// comparator results are free running analog levels, so each one
// passes two flops before any decision reads it; a comparator
// that flickers near its trip point costs latency, never a
// half-taken decision.
// a decision takes effect three edges after the comparator moves,
// which is short against any supply ramp on the board.
// on the battery the host side is dead: writes are dropped, the
// pin drivers are released, and only the comparators can bring
// the block back to the main supply.
// direct mode powers the threshold comparator down to save
// current; with the two supplies close together the selection may
// chatter, and nothing here filters that, it is left to the board.
// the block does not wake on the battery alone: it waits in reset
// state until the main supply is seen good through the flops.
// reads are answered with no wait state; prdata comes from a
// flop loaded in the setup cycle.

module battery_switchover_control #(
  parameter int STAMP_W = 48
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // analog comparators, asynchronous
  input wire logic vdd_lt_bat_i,
  input wire logic vdd_lt_thr_i,
  input wire logic bat_low_i,
  input wire logic main_ok_i,
  // current time and date for the stamp
  input wire logic [STAMP_W-1:0] time_date_i,
  // square wave source from the divider
  input wire logic square_wave_i,
  // power path and comparator control
  output logic backed_supply_out_o,
  output logic thr_mon_en_o,
  output logic bat_low_det_en_o,
  // pin drivers
  output logic square_wave_out_o,
  output logic square_wave_oe_n_o,
  output logic host_out_oe_n_o,
  // interrupt
  output logic irq_o
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (STAMP_W < 33 || STAMP_W > 64)
  begin : g_chk
    $error("STAMP_W must lie between 33 and 64");
  end

  // the synchroniser takes exactly four comparator lanes below
  if (bso_pkg::SYN_W != 4)
  begin : g_chk_lanes
    $error("synchroniser must have four lanes");
  end

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // setting to switch-over mode
  function automatic bso_pkg::mode_t mode_of(input logic [2:0] sel);
    unique case (sel)
      3'h0, 3'h1, 3'h2: mode_of = bso_pkg::MODE_STD;
      3'h3, 3'h4, 3'h5: mode_of = bso_pkg::MODE_DIRECT;
      default: mode_of = bso_pkg::MODE_OFF;
    endcase
  endfunction

  // battery-low detection enable
  function automatic logic det_of(input logic [2:0] sel);
    det_of = (sel == 3'h0) || (sel == 3'h3);
  endfunction

  // address decode for the error response
  function automatic logic in_map(input logic [7:0] addr);
    in_map = (addr == bso_pkg::CTRL_OFF)
      || (addr == bso_pkg::STATUS_OFF)
      || (addr == bso_pkg::IRQ_EN_OFF)
      || (addr == bso_pkg::STATE_OFF)
      || (addr == bso_pkg::STAMP_LO_OFF)
      || (addr == bso_pkg::STAMP_HI_OFF);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [bso_pkg::SYN_W-1:0] syn1;
    logic [bso_pkg::SYN_W-1:0] syn2;
    bso_pkg::supply_t supply;
    logic [2:0] sel;
    logic stamp_en;
    logic sw_flag;
    logic low_flag;
    logic [1:0] irq_en;
    logic [STAMP_W-1:0] stamp;
    logic [31:0] rdata;
    logic sq;
  } state_t;

  state_t st_reg;
  state_t st_next;

  bso_pkg::mode_t mode;
  logic det_en;
  logic fail;
  logic on_bat;
  logic running;
  logic setup;
  logic wr;
  logic mapped;
  logic [31:0] rd_mux;
  logic [1:0] status;
  logic wr_ctrl;
  logic wr_irq_en;
  logic wr_status;

  // ------------------------------------------------------------
  // combinational decode
  // ------------------------------------------------------------
  // mode, failure and bus qualifiers
  always_comb
  begin
    mode = mode_of(st_reg.sel);
    det_en = det_of(st_reg.sel);
    on_bat = (st_reg.supply == bso_pkg::ST_BAT);
    running = (st_reg.supply != bso_pkg::ST_WAIT);
    // threshold comparison only counts in standard mode
    unique case (mode)
      bso_pkg::MODE_STD:
        fail = st_reg.syn2[bso_pkg::SYN_LT_BAT]
          & st_reg.syn2[bso_pkg::SYN_LT_THR];
      bso_pkg::MODE_DIRECT:
        fail = st_reg.syn2[bso_pkg::SYN_LT_BAT];
      default:
        fail = 1'b0;
    endcase
    setup = psel_i & ~penable_i;
    // bus writes count only while running on the main supply; reads are always answered
    wr = psel_i & penable_i & pwrite_i & running & ~on_bat;
    // one strobe per writable register
    wr_ctrl = wr && (paddr_i == bso_pkg::CTRL_OFF);
    wr_irq_en = wr && (paddr_i == bso_pkg::IRQ_EN_OFF);
    wr_status = wr && (paddr_i == bso_pkg::STATUS_OFF);
    mapped = in_map(paddr_i);
    status = '0;
    status[bso_pkg::SWITCH_BIT] = st_reg.sw_flag;
    status[bso_pkg::LOW_BIT] = st_reg.low_flag;
  end

  // read data mux, unmapped and reserved bits read zero
  always_comb
  begin
    rd_mux = '0;
    unique case (paddr_i)
      bso_pkg::CTRL_OFF:
      begin
        rd_mux[bso_pkg::SEL_LSB +: 3] = st_reg.sel;
        rd_mux[bso_pkg::STAMP_EN_BIT] = st_reg.stamp_en;
      end
      bso_pkg::STATUS_OFF: rd_mux[1:0] = status;
      bso_pkg::IRQ_EN_OFF: rd_mux[1:0] = st_reg.irq_en;
      bso_pkg::STATE_OFF:
      begin
        rd_mux[bso_pkg::ST_BAT_BIT] = on_bat;
        rd_mux[bso_pkg::ST_RUN_BIT] = running;
        rd_mux[bso_pkg::ST_DET_BIT] = det_en;
        rd_mux[bso_pkg::ST_THR_BIT] = thr_mon_en_o;
        rd_mux[bso_pkg::ST_DIRECT_BIT] = (mode == bso_pkg::MODE_DIRECT);
      end
      bso_pkg::STAMP_LO_OFF: rd_mux = st_reg.stamp[31:0];
      bso_pkg::STAMP_HI_OFF: rd_mux[STAMP_W-33:0] = st_reg.stamp[STAMP_W-1:32];
      default: rd_mux = '0;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    // two-stage synchronisers; stage one feeds stage two only
    st_next.syn1 = {main_ok_i, bat_low_i, vdd_lt_thr_i, vdd_lt_bat_i};
    st_next.syn2 = st_reg.syn1;
    st_next.sq = square_wave_i;

    // register writes
    if (wr_ctrl)
    begin
      st_next.sel = pwdata_i[bso_pkg::SEL_LSB +: 3];
      st_next.stamp_en = pwdata_i[bso_pkg::STAMP_EN_BIT];
    end
    if (wr_irq_en)
    begin
      st_next.irq_en = pwdata_i[1:0];
    end
    // write one to clear; a switch in the same cycle wins below
    if (wr_status && pwdata_i[bso_pkg::SWITCH_BIT])
    begin
      st_next.sw_flag = 1'b0;
    end

    // supply selection
    // wait: parked after reset, host side released
    // main: normal running, host side live
    // battery: host side released until the failure goes away
    unique case (st_reg.supply)
      bso_pkg::ST_WAIT:
      begin
        // battery alone never brings the block up
        if (st_reg.syn2[bso_pkg::SYN_MAIN_OK])
        begin
          st_next.supply = bso_pkg::ST_MAIN;
        end
      end
      bso_pkg::ST_MAIN:
      begin
        if (fail)
        begin
          st_next.supply = bso_pkg::ST_BAT;
          st_next.sw_flag = 1'b1;
          if (st_reg.stamp_en)
          begin
            st_next.stamp = time_date_i;
          end
        end
      end
      bso_pkg::ST_BAT:
      begin
        // setting cannot change here, but a lost condition returns
        if (!fail)
        begin
          st_next.supply = bso_pkg::ST_MAIN;
        end
      end
      default: st_next.supply = bso_pkg::ST_WAIT;
    endcase

    // switch-over off keeps the flag cleared
    if (mode == bso_pkg::MODE_OFF)
    begin
      st_next.sw_flag = 1'b0;
    end

    // battery-low follows the detector, no command clears it
    st_next.low_flag = det_en & st_reg.syn2[bso_pkg::SYN_BAT_LOW];

    // read data captured in the setup phase
    // so prdata stands through the access phase with no wait state
    if (setup)
    begin
      st_next.rdata = rd_mux;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // reset parks the block in wait with switch-over off
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_reg.syn1 <= '0;
      st_reg.syn2 <= '0;
      st_reg.supply <= bso_pkg::ST_WAIT;
      st_reg.sel <= bso_pkg::SEL_RST;
      st_reg.stamp_en <= 1'b0;
      st_reg.sw_flag <= 1'b0;
      st_reg.low_flag <= 1'b0;
      st_reg.irq_en <= bso_pkg::IRQ_EN_RST;
      st_reg.stamp <= '0;
      st_reg.rdata <= '0;
      st_reg.sq <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // zero wait state slave; error only for an unmapped address
  // a refused write still completes without error
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o = st_reg.rdata;

  // power path select, 1 selects the battery
  assign backed_supply_out_o = on_bat;
  // threshold comparator powered only where it is used
  assign thr_mon_en_o = running & (mode == bso_pkg::MODE_STD);
  assign bat_low_det_en_o = running & det_en;

  // drivers released while on battery or before start-up
  // the square wave passes a flop so the pin sees no decode glitch
  assign square_wave_out_o = st_reg.sq;
  assign square_wave_oe_n_o = on_bat | ~running;
  assign host_out_oe_n_o = on_bat | ~running;

  // level interrupt from the sticky switch flag and the live low flag, gated by enables
  // the low flag has no clear; it drops when the detector reads good or its setting turns detection off
  assign irq_o = |(status & st_reg.irq_en);

endmodule

`default_nettype wire

/* logic/bso_pkg.sv */
// shared constants and types for the battery switch-over control block
package bso_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] IRQ_EN_OFF = 8'h08;
  localparam logic [7:0] STATE_OFF = 8'h0c;
  localparam logic [7:0] STAMP_LO_OFF = 8'h10;
  localparam logic [7:0] STAMP_HI_OFF = 8'h14;

  // control register fields
  localparam int SEL_LSB = 0;
  localparam int STAMP_EN_BIT = 3;

  // status and irq enable layout (same layout for both)
  localparam int SWITCH_BIT = 0;
  localparam int LOW_BIT = 1;

  // state register fields
  localparam int ST_BAT_BIT = 0;
  localparam int ST_RUN_BIT = 1;
  localparam int ST_DET_BIT = 2;
  localparam int ST_THR_BIT = 3;
  localparam int ST_DIRECT_BIT = 4;

  // reset values: switch-over disabled, everything else off
  localparam logic [2:0] SEL_RST = 3'h7;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;

  // synchroniser lanes of the comparator inputs
  localparam int SYN_LT_BAT = 0;
  localparam int SYN_LT_THR = 1;
  localparam int SYN_BAT_LOW = 2;
  localparam int SYN_MAIN_OK = 3;
  localparam int SYN_W = 4;

  // switch-over mode decoded from the setting
  typedef enum logic [2:0] {
    MODE_STD = 3'b001,
    MODE_DIRECT = 3'b010,
    MODE_OFF = 3'b100
  } mode_t;

  // supply state
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_MAIN = 3'b010,
    ST_BAT = 3'b100
  } supply_t;

endpackage

/* sim/bso_props.sv */
// assertion checker for the battery switch-over control block
`timescale 1ns/1ps
`default_nettype none
module bso_props (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic vdd_lt_bat_i,
  input wire logic main_ok_i,
  input wire logic square_wave_i,
  input wire logic backed_supply_out_o,
  input wire logic thr_mon_en_o,
  input wire logic bat_low_det_en_o,
  input wire logic square_wave_out_o,
  input wire logic square_wave_oe_n_o,
  input wire logic host_out_oe_n_o,
  input wire logic irq_o
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  bat_oe_off_a: assert property (
    backed_supply_out_o |-> host_out_oe_n_o && square_wave_oe_n_o)
    else $error("pins driven while on battery");
  // a switch needs the comparator seen three edges back, through the flops
  sync_switch_a: assert property (
    $rose(backed_supply_out_o) |-> $past(vdd_lt_bat_i, 3))
    else $error("switch without synchronised cause");
  start_main_a: assert property (
    $fell(host_out_oe_n_o) |-> $past(main_ok_i, 3))
    else $error("started without main supply");
  det_running_a: assert property (
    bat_low_det_en_o |-> !host_out_oe_n_o || backed_supply_out_o)
    else $error("detector enabled before start");
  thr_running_a: assert property (
    thr_mon_en_o |-> !host_out_oe_n_o || backed_supply_out_o)
    else $error("threshold monitor enabled before start");
  sqw_copy_a: assert property (
    !square_wave_oe_n_o && !$past(square_wave_oe_n_o)
    |-> square_wave_out_o == $past(square_wave_i))
    else $error("square wave not a copy of its source");
  err_access_a: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access phase");
  ready_high_a: assert property (pready_o)
    else $error("ready low");
  cover property ($rose(backed_supply_out_o));
  cover property ($rose(irq_o));
  cover property ($fell(host_out_oe_n_o));
endmodule
bind battery_switchover_control bso_props i_bso_props (.sys_clk_i,
  .sys_rst_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .vdd_lt_bat_i,
  .main_ok_i, .square_wave_i, .backed_supply_out_o, .thr_mon_en_o,
  .bat_low_det_en_o, .square_wave_out_o, .square_wave_oe_n_o,
  .host_out_oe_n_o, .irq_o);
`default_nettype wire

/* sim/supply_model.sv */
// comparator model that faces the switch-over control
`timescale 1ns/1ps
`default_nettype none
module supply_model #(
  parameter logic [7:0] THR = 8'h40,
  parameter logic [7:0] LOW = 8'h30
) (
  input wire logic sys_clk_i,
  input wire logic [7:0] vdd_i,
  input wire logic [7:0] bat_i,
  input wire logic thr_en_i,
  input wire logic det_en_i,
  output logic lt_bat_o,
  output logic lt_thr_o,
  output logic low_o,
  output logic ok_o
);
  // ----------------------------------------
  // comparators
  // ----------------------------------------
  logic junk = 1'b0;
  // a switched-off comparator is not trusted: its output wanders
  always @(posedge sys_clk_i) junk <= ~junk;
  assign lt_bat_o = vdd_i < bat_i;
  assign lt_thr_o = thr_en_i ? vdd_i < THR : junk;
  assign low_o = det_en_i ? bat_i < LOW : junk;
  assign ok_o = vdd_i > 8'h08;
endmodule
`default_nettype wire

/* sim/test_battery_switchover_control.sv */
// self-checking bench for the battery switch-over control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t value mismatch", $time); end end
module test_battery_switchover_control;
  // ----------------------------------------
  // signals and helpers
  // ----------------------------------------
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, vdd = 8'h00, bat = 8'h80;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [47:0] td = 48'h0;
  logic sqw = 0, pready, pslverr, err, lt_bat, lt_thr, blow, mok;
  logic bso, thr_en, det_en, sqo, sqoe_n, hoe_n, irq;
  logic [15:0] seed = 16'h000f;
  int n_fail = 0, num_checks = 0;
  initial forever #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) sqw <= ~sqw;
  battery_switchover_control i_battery_switchover_control (
    .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .vdd_lt_bat_i(lt_bat), .vdd_lt_thr_i(lt_thr),
    .bat_low_i(blow), .main_ok_i(mok), .time_date_i(td),
    .square_wave_i(sqw), .backed_supply_out_o(bso), .thr_mon_en_o(thr_en),
    .bat_low_det_en_o(det_en), .square_wave_out_o(sqo),
    .square_wave_oe_n_o(sqoe_n), .host_out_oe_n_o(hoe_n), .irq_o(irq));
  supply_model i_supply_model (.sys_clk_i(sys_clk), .vdd_i(vdd),
    .bat_i(bat), .thr_en_i(thr_en), .det_en_i(det_en), .lt_bat_o(lt_bat),
    .lt_thr_o(lt_thr), .low_o(blow), .ok_o(mok));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer; read data and error are taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20)
    begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // let a comparator move cross the flops, then bounded wait, then settle
  task automatic wait_bso(input logic v);
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < 12 && bso !== v; i++) @(posedge sys_clk);
    @(posedge sys_clk);
  endtask
  function automatic logic [4:0] exp_state(input logic [2:0] s);
    return {s inside {3'd3, 3'd4, 3'd5}, s < 3'd3, s == 3'd0 || s == 3'd3,
      1'b1, 1'b0};
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // ----------------------------------------
  // switch-over case: setting, main level, expected switch, irq enable
  // ----------------------------------------
  task automatic sw(input logic [2:0] s, input logic [7:0] v,
    input logic e, input logic ie);
    seed = lfsr(seed);
    td <= {seed, ~seed, seed};
    apb(1, bso_pkg::CTRL_OFF, {28'h0, 1'b1, s});
    apb(1, bso_pkg::IRQ_EN_OFF, {31'h0, ie});
    vdd <= v;
    wait_bso(e);
    `CHK(bso, e)
    if (e)
    begin
      `CHK(hoe_n & sqoe_n, 1'b1)
      `CHK(irq, ie)
      apb(1, bso_pkg::CTRL_OFF, 32'h7);
      vdd <= 8'hc0;
      wait_bso(0);
      `CHK(bso, 1'b0)
      `CHK(irq, ie)
      apb(0, bso_pkg::CTRL_OFF, 0);
      `CHK(rd[3:0], {1'b1, s})
      apb(0, bso_pkg::STAMP_LO_OFF, 0);
      `CHK(rd, td[31:0])
      apb(0, bso_pkg::STAMP_HI_OFF, 0);
      `CHK(rd, {16'h0, td[47:32]})
      apb(1, bso_pkg::STATUS_OFF, 1);
      apb(0, bso_pkg::STATUS_OFF, 0);
      `CHK(rd[0], 1'b0)
      `CHK(irq, 1'b0)
    end
    else
      `CHK(irq, 1'b0)
    vdd <= 8'hc0;
    $display("switch case done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int i;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 0;
    apb(1, bso_pkg::CTRL_OFF, 0);
    apb(0, bso_pkg::CTRL_OFF, 0);
    `CHK(rd[2:0], bso_pkg::SEL_RST)
    apb(0, bso_pkg::STATE_OFF, 0);
    `CHK(rd, 32'h0)
    `CHK(hoe_n, 1'b1)
    vdd <= 8'hc0;
    for (i = 0; i < 20 && hoe_n !== 1'b0; i++) @(posedge sys_clk);
    `CHK(hoe_n, 1'b0)
    for (int s = 0; s < 8; s++)
    begin
      apb(1, bso_pkg::CTRL_OFF, s);
      apb(0, bso_pkg::STATE_OFF, 0);
      `CHK(rd, {27'h0, exp_state(3'(s))})
      `CHK(thr_en, s < 3)
      `CHK(det_en, s == 0 || s == 3)
    end
    apb(0, 8'h40, 0);
    `CHK(err, 1'b1)
    $display("register test done");
    sw(0, 8'h60, 0, 1);
    sw(0, 8'h30, 1, 1);
    sw(3, 8'h60, 1, 0);
    sw(6, 8'h30, 0, 1);
    for (i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      sw(3'(seed % 16'd6), 8'h30, 1, seed[3]);
    end
    // battery low: detector on for setting 000, off for 001
    for (int k = 0; k < 2; k++)
    begin
      apb(1, bso_pkg::CTRL_OFF, k);
      apb(1, bso_pkg::IRQ_EN_OFF, 2);
      bat <= 8'h20;
      repeat (6) @(posedge sys_clk);
      apb(1, bso_pkg::STATUS_OFF, 2);
      apb(0, bso_pkg::STATUS_OFF, 0);
      `CHK(rd[1], k == 0)
      `CHK(irq, k == 0)
      bat <= 8'h80;
      repeat (6) @(posedge sys_clk);
      apb(0, bso_pkg::STATUS_OFF, 0);
      `CHK(rd[1], 1'b0)
      `CHK(irq, 1'b0)
    end
    $display("battery low test done");
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
